// ### inc/tcs_cfg.svh
// Constants of the top-off and trickle charge sequencer.
// Assumes a 40 MHz clock; included by every design module.
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

`define TCS_CLK_MHZ 40
`define TCS_TICK_MS 1000
`define TCS_TICK_CYC (`TCS_TICK_MS * 1000 * `TCS_CLK_MHZ)
`define TCS_TOPOFF_US 62500
`define TCS_TOPOFF_CYC (`TCS_TOPOFF_US * `TCS_CLK_MHZ)
`define TCS_TRK_STEP_US 12500
`define TCS_TRK_STEP_CYC (`TCS_TRK_STEP_US * `TCS_CLK_MHZ)
`define TCS_MEAS_NS 200
`define TCS_MEAS_CYC ((`TCS_MEAS_NS * `TCS_CLK_MHZ + 999) / 1000)

`define TCS_CNT_W 26
`define TCS_TIME_W 16

`define TCS_CMP_N 6
`define TCS_CMP_COLD 0
`define TCS_CMP_HOT 1
`define TCS_CMP_CUT 2
`define TCS_CMP_MAX 3
`define TCS_CMP_BELOW 4
`define TCS_CMP_ABOVE 5

`endif

// ### inc/tcs_pkg.sv
// Types of the top-off and trickle charge sequencer.
// Assumes tcs_cfg.svh for widths and counts.
package tcs_pkg;

  typedef enum logic [3:0] {
    TCS_IDLE = 4'h0,
    TCS_MEASURE = 4'h1,
    TCS_TOPOFF = 4'h2,
    TCS_TOP_COLD = 4'h3,
    TCS_TOP_HOT = 4'h4,
    TCS_HALT_CUT = 4'h5,
    TCS_TRICKLE = 4'h6,
    TCS_TRK_HOT = 4'h7,
    TCS_DONE = 4'h8
  } tcs_state_e;

  typedef enum logic [1:0] {
    TCS_PIN_GND = 2'h0,
    TCS_PIN_DC = 2'h1,
    TCS_PIN_ACTIVE = 2'h2
  } tcs_pin_e;

endpackage : tcs_pkg

// ### verilog/tcs_tick_gen.sv
// One-second tick prescaler.
// Assumes a synchronous, already released reset.
`timescale 1ns/1ps
`include "tcs_cfg.svh"

module tcs_tick_gen
  import tcs_pkg::*;
#(
  parameter logic [`TCS_CNT_W-1:0] TICK_CYC = `TCS_CNT_W'(`TCS_TICK_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tick
  output logic tick
);

  logic [`TCS_CNT_W-1:0] cnt_ff;
  logic tick_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == TICK_CYC - `TCS_CNT_W'(1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + `TCS_CNT_W'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule : tcs_tick_gen

// ### verilog/tcs_pulse_gen.sv
// Charge pulse of width_cyc cycles started on each one-second tick.
// Assumes the width is shorter than the tick period.
`timescale 1ns/1ps
`include "tcs_cfg.svh"

module tcs_pulse_gen
  import tcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic [`TCS_CNT_W-1:0] width_cyc,
  // Pulse
  output logic pulse
);

  logic [`TCS_CNT_W-1:0] cnt_ff;
  logic pulse_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      pulse_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= '0;
      pulse_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff <= width_cyc - `TCS_CNT_W'(1);
      pulse_ff <= 1'b1;
    end else if (pulse_ff) begin
      if (cnt_ff == '0) begin
        pulse_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - `TCS_CNT_W'(1);
      end
    end
  end

  assign pulse = pulse_ff;

endmodule : tcs_pulse_gen

// ### verilog/tcs_sequencer.sv
// Top-off, trickle maintenance, charge timer and current loop sequencer.
// Assumes comparator levels arrive asynchronously and control strobes on clk.
`timescale 1ns/1ps
`include "tcs_cfg.svh"

module tcs_sequencer
  import tcs_pkg::*;
#(
  parameter logic [`TCS_CNT_W-1:0] TICK_CYC = `TCS_CNT_W'(`TCS_TICK_CYC),
  parameter logic [`TCS_CNT_W-1:0] TOPOFF_CYC = `TCS_CNT_W'(`TCS_TOPOFF_CYC),
  parameter logic [`TCS_CNT_W-1:0] TRK_STEP_CYC = `TCS_CNT_W'(`TCS_TRK_STEP_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Temperature, voltage and current comparators
  input wire logic cold_limit_in,
  input wire logic hot_fault_limit_in,
  input wire logic hot_cutoff_limit_in,
  input wire logic max_cell_voltage_in,
  input wire logic sense_low_threshold_in,
  input wire logic sense_high_threshold_in,
  // Charge cycle control
  input wire logic charge_init_in,
  input wire logic fast_active_in,
  input wire logic fast_done_in,
  input wire logic fast_lamp_on_in,
  input wire logic sleep_in,
  input wire logic ts_sample_in,
  // Timing component measurement
  input wire logic cap_above_hi_in,
  input wire logic cap_below_lo_in,
  input wire logic res_below_lo_in,
  input wire logic [3:0] trickle_width_code,
  input wire logic [`TCS_TIME_W-1:0] max_charge_time_s,
  // Outputs
  output logic switch_control_out,
  output logic status_lamp_out,
  output logic status_lamp_oe,
  output logic [1:0] timer_program_pin,
  output logic timer_expired_out,
  output logic [3:0] charge_state_out
);

  localparam logic [3:0] MEAS_LAST = 4'(`TCS_MEAS_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and comparator synchronizers.

  logic rst_meta_ff;
  logic rst_n_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_s <= rst_meta_ff;
    end
  end

  logic [`TCS_CMP_N-1:0] cmp_raw;
  logic [`TCS_CMP_N-1:0] cmp_meta_ff;
  logic [`TCS_CMP_N-1:0] cmp_sync_ff;
  logic [`TCS_CMP_N-1:0] cmp_ff;

  assign cmp_raw = {sense_high_threshold_in, sense_low_threshold_in, max_cell_voltage_in,
                    hot_cutoff_limit_in, hot_fault_limit_in, cold_limit_in};

  for (genvar i = 0; i < `TCS_CMP_N; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
        cmp_meta_ff[i] <= 1'b0;
        cmp_sync_ff[i] <= 1'b0;
        cmp_ff[i] <= 1'b0;
      end else begin
        cmp_meta_ff[i] <= cmp_raw[i];
        cmp_sync_ff[i] <= cmp_meta_ff[i];
        cmp_ff[i] <= cmp_sync_ff[i];
      end
    end
  end

  logic cold;
  logic hot;
  logic cutoff;
  logic at_max;
  logic below;
  logic above;

  assign cold = cmp_ff[`TCS_CMP_COLD];
  assign hot = cmp_ff[`TCS_CMP_HOT] | cmp_ff[`TCS_CMP_CUT];
  assign cutoff = cmp_ff[`TCS_CMP_CUT];
  assign at_max = cmp_ff[`TCS_CMP_MAX];
  assign below = cmp_ff[`TCS_CMP_BELOW];
  assign above = cmp_ff[`TCS_CMP_ABOVE];

  ////////////////////////////////////////////////////////////////////////////
  // Tick and pulse timing.

  logic tick;
  logic pulse;
  logic pulse_en;
  logic [`TCS_CNT_W-1:0] width_cyc;
  logic [`TCS_CNT_W-1:0] trk_width_ff;

  tcs_tick_gen #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n_s),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      trk_width_ff <= TRK_STEP_CYC;
    end else begin
      trk_width_ff <= `TCS_CNT_W'(({22'h0, trickle_width_code} + 26'h1) * TRK_STEP_CYC);
    end
  end

  tcs_state_e state_ff;
  tcs_state_e nxt_state;

  assign pulse_en = (state_ff == TCS_TOPOFF) || (state_ff == TCS_TOP_COLD) ||
                    (state_ff == TCS_TRICKLE);
  assign width_cyc = (state_ff == TCS_TOPOFF) ? TOPOFF_CYC : trk_width_ff;

  tcs_pulse_gen u_pulse (
    .clk(clk),
    .rst_n(rst_n_s),
    .tick(tick),
    .enable(pulse_en),
    .width_cyc(width_cyc),
    .pulse(pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Charge timer.

  logic [`TCS_TIME_W-1:0] time_left_ff;
  logic timer_run;
  logic expired;

  assign expired = (time_left_ff == '0);
  assign timer_run = (state_ff == TCS_IDLE && fast_active_in && !cold) ||
                     (state_ff == TCS_TOPOFF) || (state_ff == TCS_TOP_HOT);

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      time_left_ff <= '0;
    end else if (charge_init_in) begin
      time_left_ff <= max_charge_time_s;
    end else if (state_ff == TCS_MEASURE && nxt_state == TCS_TOPOFF) begin
      time_left_ff <= max_charge_time_s;
    end else if (timer_run && tick && !expired) begin
      time_left_ff <= time_left_ff - `TCS_TIME_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase state machine.

  logic [3:0] meas_cnt_ff;
  logic topoff_en;

  assign topoff_en = cap_above_hi_in && res_below_lo_in && !cap_below_lo_in;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      meas_cnt_ff <= 4'h0;
    end else if (state_ff == TCS_MEASURE) begin
      meas_cnt_ff <= meas_cnt_ff + 4'h1;
    end else begin
      meas_cnt_ff <= 4'h0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    if (charge_init_in) begin
      nxt_state = TCS_IDLE;
    end else begin
      unique case (state_ff)
        TCS_IDLE: begin
          if (fast_done_in) begin
            nxt_state = TCS_MEASURE;
          end
        end
        TCS_MEASURE: begin
          if (meas_cnt_ff == MEAS_LAST) begin
            nxt_state = topoff_en ? TCS_TOPOFF : TCS_TRICKLE;
          end
        end
        TCS_TOPOFF: begin
          if (at_max) begin
            nxt_state = TCS_DONE;
          end else if (cutoff) begin
            nxt_state = TCS_HALT_CUT;
          end else if (hot) begin
            nxt_state = TCS_TOP_HOT;
          end else if (expired) begin
            nxt_state = TCS_TRICKLE;
          end else if (cold) begin
            nxt_state = TCS_TOP_COLD;
          end
        end
        TCS_TOP_COLD: begin
          if (at_max) begin
            nxt_state = TCS_DONE;
          end else if (cutoff) begin
            nxt_state = TCS_HALT_CUT;
          end else if (hot) begin
            nxt_state = TCS_TOP_HOT;
          end else if (!cold) begin
            nxt_state = TCS_TOPOFF;
          end
        end
        TCS_TOP_HOT: begin
          if (cutoff) begin
            nxt_state = TCS_HALT_CUT;
          end else if (!hot) begin
            nxt_state = expired ? TCS_TRICKLE : TCS_TOPOFF;
          end
        end
        TCS_HALT_CUT: begin
          if (!hot) begin
            nxt_state = TCS_TRICKLE;
          end
        end
        TCS_TRICKLE: begin
          if (at_max) begin
            nxt_state = TCS_DONE;
          end else if (hot) begin
            nxt_state = TCS_TRK_HOT;
          end
        end
        TCS_TRK_HOT: begin
          if (!hot) begin
            nxt_state = TCS_TRICKLE;
          end
        end
        TCS_DONE: begin
          nxt_state = TCS_DONE;
        end
        default: begin
          nxt_state = TCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_ff <= TCS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current loop and switch output.

  logic charge_gate;
  logic switch_ff;

  assign charge_gate = (state_ff == TCS_IDLE) ? fast_active_in : (pulse_en && pulse);

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      switch_ff <= 1'b0;
    end else if (!charge_gate || at_max) begin
      switch_ff <= 1'b0;
    end else if (above) begin
      switch_ff <= 1'b0;
    end else if (below) begin
      switch_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp, timer pin and status outputs.

  logic lamp_oe_ff;
  tcs_pin_e pin_ff;
  logic expired_ff;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lamp_oe_ff <= 1'b0;
    end else begin
      lamp_oe_ff <= (nxt_state == TCS_IDLE) && fast_lamp_on_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_ff <= TCS_PIN_DC;
    end else if (sleep_in || (ts_sample_in && state_ff == TCS_IDLE && fast_active_in)) begin
      pin_ff <= TCS_PIN_GND;
    end else if (timer_run && !expired) begin
      pin_ff <= TCS_PIN_ACTIVE;
    end else begin
      pin_ff <= TCS_PIN_DC;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= expired;
    end
  end

  assign switch_control_out = switch_ff;
  assign status_lamp_out = 1'b0;
  assign status_lamp_oe = lamp_oe_ff;
  assign timer_program_pin = pin_ff;
  assign timer_expired_out = expired_ff;
  assign charge_state_out = state_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_meas_start;
    (state_ff == TCS_IDLE) && fast_done_in && !charge_init_in;
  endsequence

  sequence s_meas_run;
    (state_ff == TCS_MEASURE)[*8];
  endsequence

  measure_then_phase_a: assert property (@(posedge clk) disable iff (!rst_n_s || charge_init_in)
    s_meas_start |=> s_meas_run ##1 (state_ff inside {TCS_TOPOFF, TCS_TRICKLE}))
    else $error("measure phase length or exit wrong");

  topoff_timer_load_a: assert property ((state_ff == TCS_MEASURE) && (nxt_state == TCS_TOPOFF) &&
    !charge_init_in |=> time_left_ff == $past(max_charge_time_s))
    else $error("timer not reloaded on top-off entry");

  lamp_off_a: assert property ((state_ff != TCS_IDLE) && (nxt_state != TCS_IDLE) |=> !status_lamp_oe)
    else $error("lamp driven outside fast charge");

  cold_pause_a: assert property ((state_ff == TCS_TOP_COLD) && !charge_init_in |=> $stable(time_left_ff))
    else $error("timer moved while top-off paused");

  hot_count_a: assert property ((state_ff == TCS_TOP_HOT) && tick && !expired && !charge_init_in
    |=> time_left_ff == $past(time_left_ff) - 16'h0001)
    else $error("timer stopped during hot fault");

  hot_no_charge_a: assert property ((state_ff inside {TCS_TOP_HOT, TCS_HALT_CUT, TCS_TRK_HOT}) &&
    $past(state_ff) == state_ff |-> !switch_control_out)
    else $error("switch active while hot suspended");

  cutoff_trickle_a: assert property ((state_ff == TCS_HALT_CUT) && !hot && !charge_init_in
    |=> state_ff == TCS_TRICKLE)
    else $error("cutoff did not return to trickle");

  done_hold_a: assert property ((state_ff == TCS_DONE) && !charge_init_in
    |=> (state_ff == TCS_DONE) ##1 !switch_control_out)
    else $error("charge after maximum voltage");

  clamp_off_a: assert property (at_max |=> !switch_control_out)
    else $error("switch on at maximum voltage");

  loop_high_a: assert property (charge_gate && below && !above && !at_max |=> switch_control_out)
    else $error("switch low with current below window");

  sleep_pin_a: assert property (sleep_in |=> timer_program_pin == TCS_PIN_GND)
    else $error("timer pin not low in sleep");

  trickle_pin_a: assert property ((state_ff == TCS_TRICKLE) && !sleep_in |=>
    timer_program_pin == TCS_PIN_DC)
    else $error("timer pin oscillates in trickle");

endmodule : tcs_sequencer

// ### verif/tcs_stage_model.sv
// Model of the switching power stage, battery pack and thermistor.
// Assumes the bench commands the temperature band and the battery voltage level.
`timescale 1ns/1ps

module tcs_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Switch drive and commanded conditions
  input wire logic switch_control_out,
  input wire logic [1:0] temp_band,
  input wire logic at_max,
  // Comparator results
  output logic cold_limit_in,
  output logic hot_fault_limit_in,
  output logic hot_cutoff_limit_in,
  output logic max_cell_voltage_in,
  output logic sense_low_threshold_in,
  output logic sense_high_threshold_in
);
  logic [3:0] cur_ff;

  ////////////////////////////////////////
  // Inductor current rises while the switch conducts and decays otherwise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= 4'h0;
    end else if (switch_control_out && cur_ff != 4'hf) begin
      cur_ff <= cur_ff + 4'h1;
    end else if (!switch_control_out && cur_ff != 4'h0) begin
      cur_ff <= cur_ff - 4'h1;
    end
  end

  assign sense_low_threshold_in = cur_ff < 4'h4;
  assign sense_high_threshold_in = cur_ff > 4'hb;

  ////////////////////////////////////////
  // Band 1 is cold, 2 is hot fault, 3 is hot cutoff which also asserts the hot fault comparator.
  assign cold_limit_in = temp_band == 2'h1;
  assign hot_fault_limit_in = temp_band[1];
  assign hot_cutoff_limit_in = temp_band == 2'h3;
  assign max_cell_voltage_in = at_max;
endmodule : tcs_stage_model

// ### verif/tcs_sequencer_tb.sv
// Self-checking bench of the top-off and trickle charge sequencer.
// Assumes the stage model for comparator results and shortened tick and pulse counts.
`timescale 1ns/1ps
`include "tcs_cfg.svh"

module tcs_sequencer_tb
  import tcs_pkg::*;
;
  typedef struct packed {
    logic above;
    logic below;
    logic res;
    logic [3:0] exp;
  } tcs_row_s;

  logic clk, rst_b, charge_init_in, fast_active_in, fast_done_in, fast_lamp_on_in, sleep_in, ts_sample_in;
  logic cap_above_hi_in, cap_below_lo_in, res_below_lo_in, at_max;
  logic [3:0] trickle_width_code;
  logic [`TCS_TIME_W-1:0] max_charge_time_s;
  logic [1:0] temp_band;
  logic cold, hot, cut, vmax, slo, shi, sw, lamp, lamp_oe, expired;
  logic [1:0] pin;
  logic [3:0] st;
  int errors, compares, hi;
  tcs_row_s rows [4] = '{'{1'b1, 1'b0, 1'b1, 4'h2}, '{1'b1, 1'b0, 1'b0, 4'h6}, '{1'b0, 1'b1, 1'b1, 4'h6},
    '{1'b0, 1'b0, 1'b1, 4'h6}};

  ////////////////////////////////////////
  tcs_sequencer #(.TICK_CYC(26'h64), .TOPOFF_CYC(26'h6), .TRK_STEP_CYC(26'h2)) dut (
    .clk(clk), .rst_b(rst_b), .cold_limit_in(cold), .hot_fault_limit_in(hot), .hot_cutoff_limit_in(cut),
    .max_cell_voltage_in(vmax), .sense_low_threshold_in(slo), .sense_high_threshold_in(shi),
    .charge_init_in(charge_init_in), .fast_active_in(fast_active_in), .fast_done_in(fast_done_in),
    .fast_lamp_on_in(fast_lamp_on_in), .sleep_in(sleep_in), .ts_sample_in(ts_sample_in),
    .cap_above_hi_in(cap_above_hi_in), .cap_below_lo_in(cap_below_lo_in), .res_below_lo_in(res_below_lo_in),
    .trickle_width_code(trickle_width_code), .max_charge_time_s(max_charge_time_s),
    .switch_control_out(sw), .status_lamp_out(lamp), .status_lamp_oe(lamp_oe), .timer_program_pin(pin),
    .timer_expired_out(expired), .charge_state_out(st)
  );

  tcs_stage_model stage (
    .clk(clk), .rst_b(rst_b), .switch_control_out(sw), .temp_band(temp_band), .at_max(at_max),
    .cold_limit_in(cold), .hot_fault_limit_in(hot), .hot_cutoff_limit_in(cut), .max_cell_voltage_in(vmax),
    .sense_low_threshold_in(slo), .sense_high_threshold_in(shi)
  );

  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task results;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task fin(input string nm);
    $display("Test %s finished", nm);
  endtask : fin

  task init_pulse;
    @(posedge clk);
    charge_init_in <= 1'b1;
    @(posedge clk);
    charge_init_in <= 1'b0;
  endtask : init_pulse

  task start(input tcs_row_s r, input logic [15:0] m);
    @(posedge clk);
    {cap_above_hi_in, cap_below_lo_in, res_below_lo_in} <= {r.above, r.below, r.res};
    max_charge_time_s <= m;
    charge_init_in <= 1'b1;
    @(posedge clk);
    charge_init_in <= 1'b0;
    fast_done_in <= 1'b1;
    @(posedge clk);
    fast_done_in <= 1'b0;
  endtask : start

  task wait_st(input logic [3:0] exp, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (st !== exp && i < lim);
    chk(16'(st), 16'(exp));
  endtask : wait_st

  task count_sw(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      if (sw === 1'b1) hi++;
    end
  endtask : count_sw

  task band(input logic [1:0] b);
    @(posedge clk);
    temp_band <= b;
  endtask : band

  task settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    {charge_init_in, fast_active_in, fast_done_in, fast_lamp_on_in, sleep_in, ts_sample_in} = 6'h0;
    {cap_above_hi_in, cap_below_lo_in, res_below_lo_in, at_max} = 4'h0;
    trickle_width_code = 4'h0;
    max_charge_time_s = 16'h5;
    temp_band = 2'h0;
    errors = 0;
    compares = 0;
    repeat (2) @(negedge clk);
    chk(16'({st, pin, sw, lamp_oe, expired}), 16'h0008);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    fin("reset");
    foreach (rows[k]) begin
      start(rows[k], 16'h5);
      hi = 0;
      @(negedge clk);
      while (st === 4'h1 && hi < 20) begin
        hi++;
        @(negedge clk);
      end
      chk(16'(hi), 16'h8);
      chk(16'(st), 16'(rows[k].exp));
      settle;
      chk(16'(pin), rows[k].exp == 4'h2 ? 16'h2 : 16'h1);
      chk(16'(lamp_oe), 16'h0);
    end
    fin("measure table");
    init_pulse();
    at_max <= 1'b1;
    settle;
    @(posedge clk);
    fast_active_in <= 1'b1;
    fast_lamp_on_in <= 1'b1;
    count_sw(50);
    chk(16'(hi), 16'h0);
    at_max <= 1'b0;
    count_sw(50);
    chk(16'(hi > 0 && hi < 50), 16'h1);
    chk(16'({lamp_oe, lamp}), 16'h2);
    band(2'h1);
    settle;
    chk(16'(pin), 16'h1);
    band(2'h0);
    settle;
    chk(16'(pin), 16'h2);
    ts_sample_in <= 1'b1;
    settle;
    chk(16'(pin), 16'h0);
    ts_sample_in <= 1'b0;
    sleep_in <= 1'b1;
    settle;
    chk(16'(pin), 16'h0);
    sleep_in <= 1'b0;
    fast_active_in <= 1'b0;
    fin("fast charge");
    start(rows[0], 16'h5);
    wait_st(4'h2, 20);
    count_sw(100);
    chk(16'(hi > 0 && hi <= 6), 16'h1);
    chk(16'(lamp_oe), 16'h0);
    band(2'h1);
    wait_st(4'h3, 10);
    settle;
    chk(16'(pin), 16'h1);
    count_sw(100);
    chk(16'(hi > 0 && hi <= 2), 16'h1);
    band(2'h0);
    wait_st(4'h2, 10);
    band(2'h2);
    wait_st(4'h4, 10);
    count_sw(100);
    chk(16'(hi), 16'h0);
    chk(16'(pin), 16'h2);
    band(2'h0);
    wait_st(4'h2, 10);
    wait_st(4'h6, 600);
    fin("top-off");
    start(rows[0], 16'h2);
    band(2'h2);
    wait_st(4'h4, 20);
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk(16'(expired), 16'h1);
    band(2'h0);
    wait_st(4'h6, 10);
    fin("hot until expiry");
    start(rows[0], 16'h5);
    wait_st(4'h2, 20);
    band(2'h3);
    wait_st(4'h5, 10);
    count_sw(50);
    chk(16'(hi), 16'h0);
    band(2'h0);
    wait_st(4'h6, 10);
    chk(16'(expired), 16'h0);
    fin("hot cutoff");
    @(posedge clk);
    trickle_width_code <= 4'hf;
    count_sw(100);
    count_sw(100);
    chk(16'(hi > 6 && hi < 32), 16'h1);
    chk(16'(pin), 16'h1);
    band(2'h1);
    count_sw(100);
    chk(16'({st, 4'(hi > 0)}), 16'h61);
    band(2'h2);
    wait_st(4'h7, 10);
    count_sw(100);
    chk(16'(hi), 16'h0);
    band(2'h0);
    wait_st(4'h6, 10);
    count_sw(100);
    chk(16'(hi > 0), 16'h1);
    fin("trickle");
    @(posedge clk);
    at_max <= 1'b1;
    wait_st(4'h8, 10);
    @(posedge clk);
    at_max <= 1'b0;
    count_sw(200);
    chk(16'({st, 4'(hi > 0)}), 16'h80);
    start(rows[0], 16'h5);
    wait_st(4'h2, 20);
    @(posedge clk);
    at_max <= 1'b1;
    wait_st(4'h8, 10);
    @(posedge clk);
    at_max <= 1'b0;
    init_pulse();
    wait_st(4'h0, 5);
    fin("maximum voltage");
    results();
  end
endmodule : tcs_sequencer_tb
